// File: design/kpc_config.sv
// Keypad pin function and logic event configuration register group
`timescale 1ns/1ps
`include "kpc_defs.svh"
module kpc_config #(
  parameter int STEP_CYCLES = `KPC_STEP_CYCLES
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wr_i,
  input  wire logic [7:0]       addr_i,
  input  wire logic [7:0]       wdata_i,
  output logic [7:0]            rdata_o,
  input  wire logic             logic_one_output_i,
  input  wire logic             logic_two_output_i,
  input  wire kpc_pkg::kpc_alt_t alt_i,
  output logic                  logic_one_event_o,
  output logic                  logic_two_event_o,
  output logic                  logic_one_active_o,
  output logic                  logic_two_active_o,
  output logic                  scan_start_o,
  output logic [7:0]            row_key_o,
  output logic [10:0]           col_key_o,
  output logic [18:0]           gpio_sel_o,
  output kpc_pkg::kpc_alt_t     alt_route_o
);
  typedef struct packed {
    kpc_pkg::kpc_regs_t regs;
    logic [7:0]         rdata;
    logic [31:0]        cnt;
    logic               scan;
    logic [7:0]         row_key;
    logic [10:0]        col_key;
    logic [18:0]        gpio;
    kpc_pkg::kpc_alt_t  alt;
  } kpc_st_t;
  kpc_st_t s, next_s;

  // Interval in core cycles for the two-bit code
  function automatic logic [31:0] interval(input logic [1:0] code);
    interval = 32'(STEP_CYCLES) * ({30'h0, code} + 32'h1);
  endfunction

  // Register read mux, reserved bits read zero
  function automatic logic [7:0] rd(input kpc_pkg::kpc_regs_t r,
                                    input logic [7:0] a);
    case (a)
      `KPC_ADDR_LOGIC_EVT: rd = {2'h0, r.logic_evt[5:0]};
      `KPC_ADDR_SCAN:      rd = {6'h00, r.scan};
      `KPC_ADDR_ROW:       rd = r.row;
      `KPC_ADDR_COL_LO:    rd = r.col_lo;
      `KPC_ADDR_COL_HI:    rd = {5'h00, r.col_hi};
      default:             rd = 8'h00;
    endcase
  endfunction

  // An extended route survives only while its pin is left general-purpose
  function automatic logic route_gate(input logic req, input logic key);
    route_gate = req & ~key;
  endfunction

  always_comb begin
    next_s = s;
    if (wr_i) begin
      case (addr_i)
        `KPC_ADDR_LOGIC_EVT: next_s.regs.logic_evt = wdata_i;
        `KPC_ADDR_SCAN:      next_s.regs.scan = wdata_i[1:0];
        `KPC_ADDR_ROW:       next_s.regs.row = wdata_i;
        `KPC_ADDR_COL_LO:    next_s.regs.col_lo = wdata_i;
        `KPC_ADDR_COL_HI:    next_s.regs.col_hi = wdata_i[2:0];
        default:             next_s.regs = s.regs;
      endcase
    end
    next_s.rdata = rd(s.regs, addr_i);
    // Scan timer counts core clock cycles; a shorter code takes effect
    // at once because the compare uses the live setting
    next_s.scan = 1'b0;
    if (s.cnt + 32'h1 >= interval(s.regs.scan)) begin
      next_s.cnt = 32'h0;
      next_s.scan = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 32'h1;
    end
    next_s.row_key = s.regs.row;
    next_s.col_key = {s.regs.col_hi, s.regs.col_lo};
    next_s.gpio = ~{s.regs.col_hi, s.regs.col_lo, s.regs.row};
    // Alternate routes only where the pin is still general-purpose
    next_s.alt.r0_alt = route_gate(alt_i.r0_alt, s.regs.row[0]);
    // Code 11 has no route behind it, so the pin stays plain GPIO
    next_s.alt.r3_alt = alt_i.r3_alt;
    if (s.regs.row[3] || alt_i.r3_alt == 2'h3) begin
      next_s.alt.r3_alt = 2'h0;
    end
    next_s.alt.r4_alt = route_gate(alt_i.r4_alt, s.regs.row[4]);
    next_s.alt.c4_alt = route_gate(alt_i.c4_alt, s.regs.col_lo[4]);
    next_s.alt.c6_alt = route_gate(alt_i.c6_alt, s.regs.col_lo[6]);
    next_s.alt.c9_alt = route_gate(alt_i.c9_alt, s.regs.col_hi[1]);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Two identical paths, one per logic block
  kpc_logic_event u_one (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .raw_i    (logic_one_output_i),
    .bypass_i (s.regs.logic_evt[`KPC_BIT_L1_BYPASS]),
    .enable_i (s.regs.logic_evt[`KPC_BIT_L1_EVT]),
    .level_i  (s.regs.logic_evt[`KPC_BIT_L1_LEVEL]),
    .event_o  (logic_one_event_o),
    .active_o (logic_one_active_o)
  );
  kpc_logic_event u_two (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .raw_i    (logic_two_output_i),
    .bypass_i (s.regs.logic_evt[`KPC_BIT_L2_BYPASS]),
    .enable_i (s.regs.logic_evt[`KPC_BIT_L2_EVT]),
    .level_i  (s.regs.logic_evt[`KPC_BIT_L2_LEVEL]),
    .event_o  (logic_two_event_o),
    .active_o (logic_two_active_o)
  );

  assign rdata_o = s.rdata;
  assign scan_start_o = s.scan;
  assign row_key_o = s.row_key;
  assign col_key_o = s.col_key;
  assign gpio_sel_o = s.gpio;
  assign alt_route_o = s.alt;

  // Register to pin map, two edges after a write that no second write to
  // the same register overtakes; back-to-back writes stay legal
  a_row_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == `KPC_ADDR_ROW ##1 !(wr_i && addr_i == `KPC_ADDR_ROW)
      |=> row_key_o == $past(wdata_i, 2)) else $error("row map wrong");
  a_row_gpio: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == `KPC_ADDR_ROW ##1 !(wr_i && addr_i == `KPC_ADDR_ROW)
      |=> gpio_sel_o[7:0] == ~$past(wdata_i, 2)) else $error("row gpio");
  a_col_lo_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == `KPC_ADDR_COL_LO
      ##1 !(wr_i && addr_i == `KPC_ADDR_COL_LO)
      |=> col_key_o[7:0] == $past(wdata_i, 2)) else $error("col lo map");
  a_col_hi_map: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == `KPC_ADDR_COL_HI
      ##1 !(wr_i && addr_i == `KPC_ADDR_COL_HI)
      |=> col_key_o[10:8] == $past(wdata_i[2:0], 2))
      else $error("col hi map");
  // Reserved high bits of the upper column register never read back
  a_col_hi_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == `KPC_ADDR_COL_HI ##1 addr_i == `KPC_ADDR_COL_HI
      |=> rdata_o[7:3] == 5'h00) else $error("reserved bits");
  a_gpio_excl: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (gpio_sel_o & {col_key_o, row_key_o}) == 19'h0)
    else $error("pin both gpio and key");
  // A keypad pin never carries an extended route
  a_alt_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    row_key_o[0] |-> !alt_route_o.r0_alt) else $error("r0 alt");
  a_r3_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    row_key_o[3] |-> alt_route_o.r3_alt == 2'h0) else $error("r3 alt");
  a_r4_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    row_key_o[4] |-> !alt_route_o.r4_alt) else $error("r4 alt");
  a_c4_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    col_key_o[4] |-> !alt_route_o.c4_alt) else $error("c4 alt");
  a_c6_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    col_key_o[6] |-> !alt_route_o.c6_alt) else $error("c6 alt");
  a_c9_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    col_key_o[9] |-> !alt_route_o.c9_alt) else $error("c9 alt");
  a_r3_unused: assert property (
    @(posedge clk_i) disable iff (rst_i)
    alt_route_o.r3_alt != 2'h3) else $error("r3 code 11");
  // Scan start is a single pulse that restarts the interval count
  a_scan_gap: assert property (
    @(posedge clk_i) disable iff (rst_i)
    scan_start_o |=> !scan_start_o) else $error("scan back to back");
  a_scan_count: assert property (
    @(posedge clk_i) disable iff (rst_i)
    scan_start_o |-> s.cnt == 32'h0) else $error("counter");
  c_scan: cover property (@(posedge clk_i) scan_start_o);
  c_row_wr: cover property (@(posedge clk_i) wr_i && addr_i == `KPC_ADDR_ROW);
  c_alt: cover property (@(posedge clk_i) alt_route_o.r3_alt == 2'h2);
  c_gpio_routes: cover property (@(posedge clk_i)
    gpio_sel_o == 19'h7ffff && alt_route_o.c9_alt);
endmodule

// File: design/kpc_defs.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef KPC_DEFS_SVH
`define KPC_DEFS_SVH
`define KPC_ADDR_LOGIC_EVT   8'h47
`define KPC_ADDR_SCAN        8'h48
`define KPC_ADDR_ROW         8'h49
`define KPC_ADDR_COL_LO      8'h4a
`define KPC_ADDR_COL_HI      8'h4b
`define KPC_BIT_L1_LEVEL     0
`define KPC_BIT_L1_EVT       1
`define KPC_BIT_L1_BYPASS    2
`define KPC_BIT_L2_LEVEL     3
`define KPC_BIT_L2_EVT       4
`define KPC_BIT_L2_BYPASS    5
`define KPC_RST_REG          8'h00
`define KPC_CLK_HZ           40000000
`define KPC_SCAN_STEP_MS     10
`define KPC_STEP_CYCLES      ((`KPC_CLK_HZ / 1000) * `KPC_SCAN_STEP_MS)
`define KPC_DEBOUNCE_CYCLES  4
`endif

// File: design/kpc_logic_event.sv
// One logic-block output path: debounce, bypass, level, event pulse
`timescale 1ns/1ps
`include "kpc_defs.svh"
module kpc_logic_event #(
  parameter int DEB = `KPC_DEBOUNCE_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic raw_i,
  input  wire logic bypass_i,
  input  wire logic enable_i,
  input  wire logic level_i,
  output logic      event_o,
  output logic      active_o
);
  typedef struct packed {
    logic [2:0] sync;
    logic       stable;
    logic [7:0] cnt;
    logic       prev;
    logic       evt;
  } kpc_le_t;
  kpc_le_t s, next_s;
  logic filt, act;

  // Debounced or bypassed value, then polarity
  always_comb begin
    next_s = s;
    next_s.sync = {s.sync[1:0], raw_i};
    if (s.sync[2] != s.sync[1] || s.sync[1] == s.stable) begin
      next_s.cnt = 8'h00;
    end else if (s.cnt == 8'(DEB - 1)) begin
      next_s.stable = s.sync[1];
      next_s.cnt = 8'h00;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
    filt = bypass_i ? s.sync[1] : s.stable;
    act = level_i ? filt : ~filt;
    next_s.prev = act;
    next_s.evt = enable_i && act && !s.prev;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign event_o = s.evt;
  assign active_o = s.prev;

  a_event_gated: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !enable_i |=> !event_o) else $error("event while disabled");
  a_bypass_path: assert property (
    @(posedge clk_i) disable iff (rst_i)
    bypass_i && $stable(bypass_i) && level_i && $stable(level_i)
      |-> (active_o == $past(s.sync[1]))) else $error("bypass wrong");
  c_event_seen: cover property (@(posedge clk_i) event_o);
endmodule

// File: design/kpc_pkg.sv
// Types shared by the configuration block
package kpc_pkg;
  typedef struct packed {
    logic [7:0] logic_evt;
    logic [1:0] scan;
    logic [7:0] row;
    logic [7:0] col_lo;
    logic [2:0] col_hi;
  } kpc_regs_t;
  typedef struct packed {
    logic       r0_alt;
    logic [1:0] r3_alt;
    logic       r4_alt;
    logic       c4_alt;
    logic       c6_alt;
    logic       c9_alt;
  } kpc_alt_t;
endpackage

// File: test/kpc_config_bench.sv
// Self-checking bench for the configuration register group
`timescale 1ns/1ps
module kpc_config_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr, lo1 = 1'b0, lo2 = 1'b0, ev1, ev2, act1, act2, scan, got;
  logic [7:0] addr, wdata, rdata, rowk, data;
  logic [10:0] colk;
  logic [18:0] gsel;
  kpc_pkg::kpc_alt_t alt = '0, altr;
  logic [7:0] q[$];
  logic [7:0] v[6];
  logic [7:0] mask[6] = '{8'h3f, 8'h03, 8'hff, 8'hff, 8'h07, 8'h00};
  int bad_count = 0, checks_done = 0, n1 = 0, n2 = 0, n;
  always #12.5 clk_i = ~clk_i;
  kpc_host i_host (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr), .addr_o(addr),
    .wdata_o(wdata), .got_o(got), .data_o(data));
  kpc_config #(.STEP_CYCLES(10)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .logic_one_output_i(lo1), .logic_two_output_i(lo2), .alt_i(alt),
    .logic_one_event_o(ev1), .logic_two_event_o(ev2),
    .logic_one_active_o(act1), .logic_two_active_o(act2),
    .scan_start_o(scan), .row_key_o(rowk), .col_key_o(colk),
    .gpio_sel_o(gsel), .alt_route_o(altr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    i_host.read(a);
  endtask
  // Oldest expected read value is matched against each returned read
  always @(posedge clk_i) begin
    if (got === 1'b1) chk(data, q.pop_front());
  end
  // Event pulses are counted so short pulses are never missed
  always @(posedge clk_i) begin
    n1 += int'(ev1 === 1'b1);
    n2 += int'(ev2 === 1'b1);
  end
  task automatic waitp();
    n = 0;
    do begin
      @(posedge clk_i);
      #2;
      n++;
    end while (scan !== 1'b1 && n < 200);
  endtask
  // First gap after a code change may be short, so measure the next one
  task automatic interval(input logic [1:0] c);
    i_host.write(8'h48, {6'h00, c});
    i_host.idle();
    waitp();
    waitp();
    chk(n, 10 * (c + 1));
  endtask
  // Both blocks share one setting: {bypass, enable, level}
  task automatic ev(input logic [2:0] c, input int w, input int e);
    i_host.write(8'h47, {2'b00, c, c});
    i_host.idle();
    {lo1, lo2} = {2{~c[0]}};
    repeat (12) @(posedge clk_i);
    #2;
    n1 = 0;
    n2 = 0;
    {lo1, lo2} = {2{c[0]}};
    repeat (w) @(posedge clk_i);
    #2;
    if (w >= 12) chk({act1, act2}, 2'b11);
    {lo1, lo2} = {2{~c[0]}};
    repeat (15) @(posedge clk_i);
    #2;
    chk(n1, e);
    chk(n2, e);
  endtask
  initial begin
    void'($urandom(32'hc64b));
    repeat (2) @(posedge clk_i);
    #2 rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #2;
    chk(gsel, 19'h7ffff);
    for (int i = 0; i < 6; i++) rd(8'(8'h47 + i), 8'h00);
    for (int i = 0; i < 6; i++) begin
      v[i] = 8'($urandom);
      i_host.write(8'(8'h47 + i), v[i]);
    end
    i_host.idle();
    for (int i = 0; i < 6; i++) rd(8'(8'h47 + i), v[i] & mask[i]);
    chk(rowk, v[2]);
    chk(colk, {v[4][2:0], v[3]});
    chk(gsel, 19'(~{v[4][2:0], v[3], v[2]}));
    // All pins as GPIO: routes pass, row-3 code 11 is dropped
    for (int i = 0; i < 3; i++) i_host.write(8'(8'h49 + i), 8'h00);
    i_host.idle();
    for (int r = 0; r < 4; r++) begin
      alt = {1'b1, 2'(r), 4'hf};
      repeat (3) @(posedge clk_i);
      #2;
      chk(altr, {1'b1, (r == 3) ? 2'b00 : 2'(r), 4'hf});
    end
    for (int i = 0; i < 3; i++) i_host.write(8'(8'h49 + i), 8'hff);
    i_host.idle();
    repeat (3) @(posedge clk_i);
    #2;
    chk(altr, 7'h00);
    for (int c = 0; c < 4; c++) interval(2'(c));
    // Bypass is only used with clean pulses, glitches would fire early
    ev(3'b011, 2, 0);
    ev(3'b111, 2, 1);
    ev(3'b011, 12, 1);
    ev(3'b001, 12, 0);
    ev(3'b010, 12, 1);
    ev(3'b110, 1, 1);
    stop_test();
  end
  // Watchdog well beyond the expected run of under 500 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end
endmodule

// File: test/kpc_host.sv
// Host model that writes and reads the configuration registers
`timescale 1ns/1ps
module kpc_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            wr_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o,
  output logic            got_o,
  output logic [7:0]      data_o
);
  initial begin
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
    got_o = 1'b0;
    data_o = 8'h00;
  end
  // Strobe stays high so writes can follow each other every cycle
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #2;
  endtask
  // Stale data is inverted so it never looks like a valid write
  task automatic idle();
    wr_o = 1'b0;
    wdata_o = ~wdata_o;
  endtask
  // Read data is registered, so it is taken one edge after the address
  task automatic read(input logic [7:0] a);
    // Strobe is already low here: callers read before any write or after idle
    addr_o = a;
    @(posedge clk_i);
    #2;
    data_o = rdata_i;
    got_o = 1'b1;
    @(posedge clk_i);
    #2;
    got_o = 1'b0;
  endtask
endmodule
